/* pfp_defines.vh */
/*
 * constants for the function power-state control block: register
 * offsets, field positions, reset values, state codes and timing counts.
 * assumes a 250 MHz register clock (4 ns period).
 */
`ifndef PFP_DEFINES_VH
`define PFP_DEFINES_VH

// register byte offsets
`define PFP_CAP_OFS 8'h00
`define PFP_CSR_OFS 8'h04
`define PFP_CTL_OFS 8'h08
`define PFP_STS_OFS 8'h0C

// capability register fields
`define PFP_CAP_DSI_BIT 5
`define PFP_CAP_D1_BIT 9
`define PFP_CAP_D2_BIT 10

// control/status register fields
`define PFP_CSR_STATE_LSB 0
`define PFP_CSR_WAKE_EN_BIT 8

// status register fields
`define PFP_STS_BUSY_BIT 0
`define PFP_STS_READY_BIT 1
`define PFP_STS_REJECT_BIT 2

// power state codes
`define PFP_D0 2'h0
`define PFP_D1 2'h1
`define PFP_D2 2'h2
`define PFP_D3 2'h3

// reset values
`define PFP_CSR_RST 32'h00000000
`define PFP_CTL_RST 32'h00000000

// timing
`define PFP_CLK_MHZ 250
`define PFP_READY_MS 10
`define PFP_READY_CYC (`PFP_READY_MS * 1000 * `PFP_CLK_MHZ)
`define PFP_SETTLE_CYC 8'h10

`endif

/* pfp_sync2.v */
/*
 * two-flop synchroniser for one level input.
 * assumes the input is asynchronous to clk_i.
 */
`timescale 1ns/1ps
module pfp_sync2 (
	input wire clk_i,
	input wire rst_i,
	input wire d_i,
	output wire q_o
);
	reg meta_r;
	reg sync_r;

	// first flop feeds only the second
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule // pfp_sync2

/* pfp_counter.v */
/*
 * down counter with load; done flags zero.
 * assumes load and count are from the same clock domain.
 */
`timescale 1ns/1ps
module pfp_counter #(
	parameter W = 24
) (
	input wire clk_i,
	input wire rst_i,
	input wire load_i,
	input wire [W-1:0] value_i,
	output wire done_o
);
	reg [W-1:0] cnt_r;

	// counts down to zero and holds there
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= {W{1'b0}};
		end else if (load_i) begin
			cnt_r <= value_i;
		end else if (cnt_r != {W{1'b0}}) begin
			cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign done_o = (cnt_r == {W{1'b0}});
endmodule // pfp_counter

/* pfp_power_ctrl.v */
/*
 * function power-state control behind a classic wishbone slave.
 * holds the capability register, the control/status register with the
 * power state and wake enable, a control register and a status register.
 * assumes a single 250 MHz clock, synchronous active-high reset, and a
 * wake request pin that is asynchronous to the clock.
 */
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "pfp_defines.vh"
module pfp_power_ctrl #(
	parameter READY_CYC = `PFP_READY_CYC,
	parameter SUPPORT_D1 = 1,
	parameter SUPPORT_D2 = 1,
	parameter DSI_REQUIRED = 0
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	output wire err_o,
	input wire wake_req_i,
	output wire wake_n_o,
	output wire wake_n_oe_o,
	output wire [1:0] power_state_o,
	output wire func_ready_o,
	output wire io_enable_o
);
	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	reg ack_r;
	wire req = cyc_i & stb_i & ~ack_r;
	// writes land on the edge where the master samples ack high, not before
	wire wr = cyc_i & stb_i & we_i & ack_r;
	wire rd = req & ~we_i;
	wire hit_cap = (adr_i == `PFP_CAP_OFS);
	wire hit_csr = (adr_i == `PFP_CSR_OFS);
	wire hit_ctl = (adr_i == `PFP_CTL_OFS);
	wire hit_sts = (adr_i == `PFP_STS_OFS);
	wire mapped = hit_cap | hit_csr | hit_ctl | hit_sts;

	// one cycle ack; unmapped reads give zero, unmapped writes are dropped
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end
	assign ack_o = ack_r;
	assign err_o = 1'b0; // invalid state writes are not an error

	// ****************************************************************
	// capability register
	// ****************************************************************
	wire [31:0] cap_val;
	assign cap_val = {16'h0000,
		5'h00,
		(SUPPORT_D2 != 0),
		(SUPPORT_D1 != 0),
		3'h0,
		(DSI_REQUIRED != 0),
		5'h00}; // dsi flag at bit 5

	// ****************************************************************
	// power state and wake enable
	// ****************************************************************
	reg [1:0] state_r;
	reg [1:0] target_r;
	reg wake_en_r;
	reg busy_r;
	reg reject_r;
	reg [31:0] ctl_r;
	wire settle_done;
	wire [1:0] wr_state = dat_i[`PFP_CSR_STATE_LSB+1:`PFP_CSR_STATE_LSB];

	// D0 and D3 are always taken; D1 and D2 only when the capability register reports them
	reg supported;
	always @* begin
		case (wr_state)
			`PFP_D0: supported = 1'b1;
			`PFP_D1: supported = (SUPPORT_D1 != 0);
			`PFP_D2: supported = (SUPPORT_D2 != 0);
			`PFP_D3: supported = 1'b1;
			default: supported = 1'b0;
		endcase
	end

	wire csr_wr = wr & hit_csr;
	wire state_wr_lo = csr_wr & sel_i[0];
	wire state_go = state_wr_lo & supported & (wr_state != target_r);

	// settle timer models the transition taking effect
	pfp_counter #(
		.W(8)
	) u_settle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(state_go),
		.value_i(`PFP_SETTLE_CYC),
		.done_o(settle_done)
	);

	// state field moves only after the transition completes
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= `PFP_D0;
			target_r <= `PFP_D0;
			busy_r <= 1'b0;
		end else if (state_go) begin
			target_r <= wr_state; // accept supported code
			busy_r <= 1'b1;
		end else if (busy_r & settle_done) begin
			state_r <= target_r; // field reflects entered state
			busy_r <= 1'b0;
		end
	end

	// an unsupported code leaves state untouched and only sets a sticky flag
	always @(posedge clk_i) begin
		if (rst_i) begin
			reject_r <= 1'b0;
		end else if (state_wr_lo & ~supported) begin
			reject_r <= 1'b1; // write data discarded
		end else if (wr & hit_sts & sel_i[0] & dat_i[`PFP_STS_REJECT_BIT]) begin
			reject_r <= 1'b0;
		end
	end

	// wake enable and control register
	always @(posedge clk_i) begin
		if (rst_i) begin
			wake_en_r <= 1'b0;
			ctl_r <= `PFP_CTL_RST;
		end else begin
			if (csr_wr & sel_i[1]) begin
				wake_en_r <= dat_i[`PFP_CSR_WAKE_EN_BIT];
			end
			if (wr & hit_ctl & sel_i[0]) begin
				ctl_r <= {31'h00000000, dat_i[0]};
			end
		end
	end

	// ****************************************************************
	// post-reset readiness
	// ****************************************************************
	reg ready_load_r;
	wire ready_done;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ready_load_r <= 1'b1;
		end else begin
			ready_load_r <= 1'b0;
		end
	end

	// readiness window after reset; must not exceed the 10 ms limit
	pfp_counter #(
		.W(22)
	) u_ready (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(ready_load_r),
		.value_i(READY_CYC[21:0]),
		.done_o(ready_done)
	);
	assign func_ready_o = ready_done & ~ready_load_r;

	// ****************************************************************
	// wake line
	// ****************************************************************
	wire wake_sync;
	pfp_sync2 u_wake_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(wake_req_i),
		.q_o(wake_sync)
	);
	// open drain: drive low only when enabled
	assign wake_n_o = 1'b0;
	assign wake_n_oe_o = wake_sync & wake_en_r;

	// io enable mirrors software control, forced off outside D0
	assign io_enable_o = ctl_r[0] & (state_r == `PFP_D0);
	assign power_state_o = state_r;

	// ****************************************************************
	// read data
	// ****************************************************************
	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h00000000;
		if (hit_cap) begin
			rd_val = cap_val;
		end else if (hit_csr) begin
			rd_val = {23'h000000, wake_en_r, 6'h00, state_r};
		end else if (hit_ctl) begin
			rd_val = ctl_r;
		end else if (hit_sts) begin
			rd_val = {29'h00000000, reject_r, func_ready_o, busy_r};
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (rd & mapped) begin
			dat_o <= rd_val;
		end else if (rd) begin
			dat_o <= 32'h00000000;
		end
	end
endmodule // pfp_power_ctrl

/* pfp_host_model.sv */
/* software side model: one classic wishbone master.
   assumes one clock and a slave that answers every request with ack. */
`timescale 1ns/1ps
module pfp_host_model (
	input wire clk_i,
	input wire ack_i,
	input wire [31:0] rdat_i,
	output reg cyc_o = 1'b0,
	output reg stb_o = 1'b0,
	output reg we_o = 1'b0,
	output reg [7:0] adr_o = 8'h00,
	output reg [3:0] sel_o = 4'h0,
	output reg [31:0] dat_o = 32'h00000000
);
	// ****
	// transfer
	// ****
	// one request at a time, so nothing is left pending before a state change
	task xfer(input w, input [7:0] a, input [3:0] s, input [31:0] d, output [31:0] q);
		begin
			@(posedge clk_i);
			cyc_o <= 1'b1;
			stb_o <= 1'b1;
			we_o <= w;
			adr_o <= a;
			sel_o <= s;
			dat_o <= d;
			@(posedge clk_i);
			while (ack_i !== 1'b1) @(posedge clk_i);
			q = rdat_i;
			cyc_o <= 1'b0;
			stb_o <= 1'b0;
			adr_o <= ~a; // a released bus must not look valid
			dat_o <= ~d;
		end
	endtask
endmodule // pfp_host_model

/* pfp_power_chk.sv */
/* port checker for the power-state block.
   assumes a bind onto pfp_power_ctrl and one clock domain. */
`timescale 1ns/1ps
`include "pfp_defines.vh"
module pfp_power_chk #(
	parameter READY_CYC = 20,
	parameter SUPPORT_D1 = 1,
	parameter SUPPORT_D2 = 1,
	parameter DSI_REQUIRED = 0
) (
	input wire clk_i,
	input wire rst_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire err_o,
	input wire wake_req_i,
	input wire wake_n_o,
	input wire wake_n_oe_o,
	input wire [1:0] power_state_o,
	input wire func_ready_o
);
	// ****
	// helpers
	// ****
	wire wr_csr = ack_o & we_i & sel_i[0] & (adr_i == `PFP_CSR_OFS);
	wire rd_ack = ack_o & ~we_i;
	wire bad = ((dat_i[1:0] == `PFP_D2) && (SUPPORT_D2 == 0)) ||
		((dat_i[1:0] == `PFP_D1) && (SUPPORT_D1 == 0));
	reg [31:0] cnt_r;
	// cycles since reset release; saturates so it never wraps
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 32'h0;
		end else if (cnt_r != 32'hFFFFFFFF) begin
			cnt_r <= cnt_r + 32'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_no_err; !err_o; endproperty
	a_no_err: assert property (p_no_err) else $error("error response");
	property p_reject; wr_csr && bad |=> $stable(power_state_o) [*8]; endproperty
	a_reject: assert property (p_reject) else $error("rejected state entered");
	// read data is registered on the same edge that raises ack, so compare with the state seen then
	property p_readback; rd_ack && adr_i == `PFP_CSR_OFS |-> dat_o[1:0] == $past(power_state_o);
	endproperty
	a_readback: assert property (p_readback) else $error("state readback");
	property p_dsi; rd_ack && adr_i == `PFP_CAP_OFS |-> dat_o[5] == (DSI_REQUIRED != 0); endproperty
	a_dsi: assert property (p_dsi) else $error("init flag");
	property p_wake; wake_n_oe_o |-> $past(wake_req_i, 2) && !wake_n_o; endproperty
	a_wake: assert property (p_wake) else $error("wake drive");
	property p_ready; cnt_r == READY_CYC + 5 |-> func_ready_o; endproperty
	a_ready: assert property (p_ready) else $error("ready late");
	property p_move; wr_csr && !bad |-> ##18 power_state_o == $past(dat_i[1:0], 18); endproperty
	a_move: assert property (p_move) else $error("state not entered");
	// reset drops the state to D0 too; the release edge is not covered by disable iff
	property p_hold; !$stable(power_state_o) |-> rst_i || $past(rst_i) || $past(wr_csr, 17) ||
		$past(wr_csr, 18); endproperty
	a_hold: assert property (p_hold) else $error("state changed unasked");
	c_reject: cover property (wr_csr && bad);
	c_wake: cover property (wake_n_oe_o);
	c_ready: cover property ($rose(func_ready_o));
endmodule // pfp_power_chk
bind pfp_power_ctrl pfp_power_chk #(.READY_CYC(READY_CYC), .SUPPORT_D1(SUPPORT_D1),
	.SUPPORT_D2(SUPPORT_D2),
	.DSI_REQUIRED(DSI_REQUIRED)) u_chk (.clk_i, .rst_i, .we_i, .adr_i, .sel_i, .dat_i,
	.dat_o, .ack_o, .err_o, .wake_req_i, .wake_n_o, .wake_n_oe_o, .power_state_o,
	.func_ready_o);

/* pfp_power_ctrl_test.sv */
/* self-checking bench for the power-state block.
   assumes pfp_host_model as bus master and a short ready window. */
`timescale 1ns/1ps
`include "pfp_defines.vh"
module pfp_power_ctrl_test;
	localparam RC = 20;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg wake_i = 1'b0;
	wire cyc, stb, we, ack, err, wn, woe, rdy, ioe;
	wire [7:0] adr;
	wire [3:0] sel;
	wire [31:0] wd, rd_d;
	wire [1:0] ps;
	reg [31:0] q;
	reg [1:0] st;
	integer n_mismatch = 0;
	integer checked = 0;
	integer i;
	always #2 clk_i = ~clk_i;
	// D2 left out so a refused code can be written
	pfp_power_ctrl #(.READY_CYC(RC), .SUPPORT_D2(0), .DSI_REQUIRED(1)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wd), .dat_o(rd_d), .ack_o(ack), .err_o(err), .wake_req_i(wake_i),
		.wake_n_o(wn), .wake_n_oe_o(woe), .power_state_o(ps), .func_ready_o(rdy),
		.io_enable_o(ioe));
	pfp_host_model host (.clk_i(clk_i), .ack_i(ack), .rdat_i(rd_d), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
	// ****
	// tasks
	// ****
	task wr(input [7:0] a, input [3:0] s, input [31:0] d);
		host.xfer(1'b1, a, s, d, q);
	endtask
	task rd(input [7:0] a);
		host.xfer(1'b0, a, 4'hF, 32'h0, q);
	endtask
	task cmp(input string nm, input [31:0] e, input [31:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task rst_for(input integer n);
		begin
			@(posedge clk_i);
			rst_i <= 1'b1;
			repeat (n) @(posedge clk_i);
			rst_i <= 1'b0;
		end
	endtask
	task complete_run;
		begin
			if (n_mismatch == 0 && checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// ****
	// sequence
	// ****
	initial begin
		rst_for(12);
		repeat (RC + 6) @(posedge clk_i);
		cmp("ready", 1, rdy);
		rd(`PFP_CAP_OFS);
		cmp("dsi", 1, q[`PFP_CAP_DSI_BIT]);
		cmp("capability", 32'h00000220, q);
		rd(8'h10);
		cmp("unmapped", 0, q);
		wr(`PFP_CTL_OFS, 4'h1, 32'h0);
		cmp("io off", 0, ioe);
		st = `PFP_D0;
		// D1, refused D2, D3, back to D0
		for (i = 1; i < 5; i = i + 1) begin
			wr(`PFP_CSR_OFS, 4'h1, i % 4);
			rd(`PFP_CSR_OFS);
			cmp("state early", st, q[1:0]);
			if (i != 2) st = i % 4;
			repeat (20) @(posedge clk_i);
			cmp("state", st, ps);
			rd(`PFP_CSR_OFS);
			cmp("state read", st, q[1:0]);
		end
		// refused D2 code left the sticky flag; busy is long gone, ready is up
		rd(`PFP_STS_OFS);
		cmp("status", 32'h00000006, q);
		wr(`PFP_STS_OFS, 4'h1, 32'h00000004);
		rd(`PFP_STS_OFS);
		cmp("status clear", 32'h00000002, q);
		wr(`PFP_CSR_OFS, 4'h1, 32'h3);
		repeat (20) @(posedge clk_i);
		cmp("state d3", 3, ps);
		rst_for(2);
		cmp("state reset", 0, ps);
		repeat (RC + 6) @(posedge clk_i);
		cmp("ready again", 1, rdy);
		wr(`PFP_CTL_OFS, 4'h1, 32'h1);
		wake_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		cmp("wake gated", 0, woe);
		wr(`PFP_CSR_OFS, 4'h2, 32'h100);
		repeat (2) @(posedge clk_i);
		cmp("wake on", 1, woe);
		cmp("wake level", 0, wn);
		cmp("io on", 1, ioe);
		wake_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		cmp("wake off", 0, woe);
		complete_run;
	end
	// watchdog; the whole sequence needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk_i);
		n_mismatch = n_mismatch + 1;
		complete_run;
	end
endmodule // pfp_power_ctrl_test
